// file: include/zqc_defines.svh
// Offsets, field positions, reset values and timing of the impedance regs
`ifndef ZQC_DEFINES_SVH
`define ZQC_DEFINES_SVH

// ----------------------------------------------------------------------
// Address map (byte addresses, 8-bit APB address)
// ----------------------------------------------------------------------
`define ZQC_NUM_BLOCKS    4
`define ZQC_CR1_RGN       4'h0
`define ZQC_SR0_RGN       4'h1
`define ZQC_TGT_RGN       4'h3
`define ZQC_CALCTL_ADDR   8'h20
`define ZQC_IRQSTAT_ADDR  8'h24
`define ZQC_IRQCLR_ADDR   8'h28
`define ZQC_IRQEN_ADDR    8'h2C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ZQC_DIV_MSB       7
`define ZQC_DIV_LSB       0
`define ZQC_PUEN_BIT      16
`define ZQC_TRIG_BIT      8
`define ZQC_DIV_RST       8'h7B
`define ZQC_WORD_RST      28'h000014A
`define ZQC_CALEN_RST     4'hF

// ----------------------------------------------------------------------
// Divide-select codes and the ohm values they stand for
// ----------------------------------------------------------------------
`define ZQC_ODT_SEL_120   4'h2
`define ZQC_ODT_SEL_60    4'h5
`define ZQC_ODT_SEL_40    4'h8
`define ZQC_DRV_SEL_40    4'hB
`define ZQC_DRV_SEL_34    4'hD
`define ZQC_OHM_120       8'h78
`define ZQC_OHM_60        8'h3C
`define ZQC_OHM_40        8'h28
`define ZQC_OHM_34        8'h22

// ----------------------------------------------------------------------
// Periodic update request spacing
// ----------------------------------------------------------------------
`define ZQC_CLK_MHZ       40
`define ZQC_UPD_PERIOD_NS 10000
`define ZQC_UPD_CYCLES    ((`ZQC_UPD_PERIOD_NS * `ZQC_CLK_MHZ) / 1000)
`define ZQC_UPD_CNT_W     9

`endif

// file: include/zqc_pkg.sv
// Types shared by the impedance calibration register bank
package zqc_pkg;

  typedef enum logic {
    ZQC_IDLE,
    ZQC_CAL
  } zqc_cal_state_t;

  // Result handed back by the pad calibration engine
  typedef struct packed {
    logic        valid;
    logic        error;
    logic [27:0] word;
  } zqc_result_t;

  // Settings that go out to the pads
  typedef struct packed {
    logic [7:0]  divRatio;
    logic [27:0] word;
  } zqc_pad_t;

  typedef struct packed {
    zqc_pad_t pad;
    logic     periodicEn;
    logic     done;
    logic     err;
    logic     busy;
    logic     calStart;
    logic     updateReq;
    logic     doneEv;
    logic     errEv;
  } zqc_unit_out_t;

  typedef struct packed {
    zqc_unit_out_t  out;
    zqc_cal_state_t cal;
  } zqc_unit_state_t;

  typedef struct packed {
    logic                       cnt;
  } zqc_unused_t;

endpackage

// file: design/zqc_tick_div.sv
// Divider giving the one-cycle pulse that paces periodic update requests
`timescale 1ns/100ps
`include "zqc_defines.svh"

module zqc_tick_div (
  input  wire logic clk,
  input  wire logic resetn,
  output logic      tick
);

  typedef struct packed {
    logic [`ZQC_UPD_CNT_W-1:0] cnt;
    logic                      tick;
  } zqc_div_state_t;

  localparam logic [`ZQC_UPD_CNT_W-1:0] LAST =
    `ZQC_UPD_CNT_W'(`ZQC_UPD_CYCLES - 1);

  zqc_div_state_t st;
  zqc_div_state_t next_st;

  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt == LAST) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + `ZQC_UPD_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule // zqc_tick_div

// file: design/zqc_unit.sv
// One impedance calibration block: divide/update control and status
`timescale 1ns/100ps
`include "zqc_defines.svh"

module zqc_unit (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  wrEn,
  input  wire logic [31:0]           wdata,
  input  wire logic                  calEnable,
  input  wire logic                  trigger,
  input  wire logic                  tick,
  input  zqc_pkg::zqc_result_t       result,
  output zqc_pkg::zqc_unit_out_t     uout
);

  zqc_pkg::zqc_unit_state_t st;
  zqc_pkg::zqc_unit_state_t next_st;

  always_comb begin
    next_st               = st;
    next_st.out.calStart  = 1'b0;
    next_st.out.updateReq = 1'b0;
    next_st.out.doneEv    = 1'b0;
    next_st.out.errEv     = 1'b0;
    if (wrEn) begin
      next_st.out.pad.divRatio = wdata[`ZQC_DIV_MSB:`ZQC_DIV_LSB]; // RULE5
      next_st.out.periodicEn   = wdata[`ZQC_PUEN_BIT];
    end
    case (st.cal)
      zqc_pkg::ZQC_IDLE: begin
        if (trigger && calEnable) begin // RULE12
          next_st.out.done     = 1'b0; // RULE13
          next_st.out.err      = 1'b0; // RULE13
          next_st.out.calStart = 1'b1;
          next_st.cal          = zqc_pkg::ZQC_CAL;
        end else if (tick && st.out.periodicEn) begin
          next_st.out.updateReq = 1'b1; // RULE3
        end
      end
      zqc_pkg::ZQC_CAL: begin
        // Periodic request ticks are dropped while a calibration is running
        if (result.valid) begin
          next_st.out.done     = 1'b1; // RULE8
          next_st.out.err      = result.error; // RULE9
          next_st.out.pad.word = result.word; // RULE10
          next_st.out.doneEv   = 1'b1;
          next_st.out.errEv    = result.error;
          next_st.cal          = zqc_pkg::ZQC_IDLE;
        end
      end
      default: next_st.cal = zqc_pkg::ZQC_IDLE;
    endcase
    next_st.out.busy = (next_st.cal == zqc_pkg::ZQC_CAL);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st                  <= '0;
      st.out.pad.divRatio <= `ZQC_DIV_RST; // RULE5
      st.out.pad.word     <= `ZQC_WORD_RST; // RULE10
    end else begin
      st <= next_st;
    end
  end

  assign uout = st.out;

endmodule // zqc_unit

// file: design/zqc_regs.sv
// APB register bank for four impedance calibration blocks
//
// Operation
// RULE1: Four independent control/status register sets, blocks 0 to 3.
// RULE2: Reserved control bits 31:17, 15:8 and status 29:28 read zero.
// RULE3: Update enable bit 16 set makes periodic update requests; clear stops.
// RULE4: Software should set the periodic update enable during configuration.
// RULE5: Divide ratio bits 7:0 read/write, reset value 7B hex.
// RULE6: Upper nibble picks termination: 2=120, 5=60, 8=40 ohms.
// RULE7: Lower nibble picks driver impedance: 11=40, 13=34 ohms.
// RULE8: Status bit 31 flags calibration finished, zero after reset.
// RULE9: Status bit 30 flags calibration error, zero after reset.
// RULE10: Status bits 27:0 show applied control word, reset 14A hex.
// RULE11: Control word splits into four 7-bit pull-up/pull-down fields.
// RULE12: Calibration starts only with enable set and a trigger arriving.
// RULE13: New trigger clears done/error; done updates with word at end.
`timescale 1ns/100ps
`include "zqc_defines.svh"

module zqc_regs (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        dfiUpdateReq,
  input  zqc_pkg::zqc_result_t [3:0]       calResult,
  output logic      [3:0]                  calStart,
  output logic      [3:0]                  updateReq,
  output zqc_pkg::zqc_pad_t [3:0]          padCtrl,
  output logic                             irq
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [3:0]  calEn;
    logic        trig;
    logic [7:0]  irqStatus;
    logic [7:0]  irqEnable;
    logic        irq;
  } zqc_top_state_t;

  zqc_top_state_t st;
  zqc_top_state_t next_st;

  zqc_pkg::zqc_unit_out_t [3:0] uo;
  logic [3:0]                   unitWr;
  logic                         tick;
  logic                         trigger;
  logic                         accSetup;
  logic                         accWrite;
  logic                         hit;
  logic [31:0]                  rdData;
  logic [1:0]                   idx;
  logic [3:0]                   busyVec;
  logic [7:0]                   events;

  // --------------------------------------------------------------------
  // Target decode helpers
  // --------------------------------------------------------------------
  function automatic logic [7:0] odtOhms(input logic [3:0] sel);
    logic [7:0] ohm;
    ohm = 8'h00;
    case (sel)
      `ZQC_ODT_SEL_120: ohm = `ZQC_OHM_120; // RULE6
      `ZQC_ODT_SEL_60:  ohm = `ZQC_OHM_60; // RULE6
      `ZQC_ODT_SEL_40:  ohm = `ZQC_OHM_40; // RULE6
      default:          ohm = 8'h00;
    endcase
    return ohm;
  endfunction

  function automatic logic [7:0] drvOhms(input logic [3:0] sel);
    logic [7:0] ohm;
    ohm = 8'h00;
    case (sel)
      `ZQC_DRV_SEL_40: ohm = `ZQC_OHM_40; // RULE7
      `ZQC_DRV_SEL_34: ohm = `ZQC_OHM_34; // RULE7
      default:         ohm = 8'h00;
    endcase
    return ohm;
  endfunction

  // --------------------------------------------------------------------
  // Calibration blocks
  // --------------------------------------------------------------------
  // Either source of trigger reaches every block; each gates it itself
  assign trigger = st.trig | dfiUpdateReq; // RULE12

  zqc_tick_div u_tick (
    .clk    (clk),
    .resetn (resetn),
    .tick   (tick)
  );

  for (genvar i = 0; i < `ZQC_NUM_BLOCKS; i++) begin : g_unit
    zqc_unit u_unit ( // RULE1
      .clk       (clk),
      .resetn    (resetn),
      .wrEn      (unitWr[i]),
      .wdata     (pwdata),
      .calEnable (st.calEn[i]),
      .trigger   (trigger),
      .tick      (tick),
      .result    (calResult[i]),
      .uout      (uo[i])
    );
  end

  // --------------------------------------------------------------------
  // Address decode and read mux
  // --------------------------------------------------------------------
  assign idx = paddr[3:2];

  always_comb begin
    busyVec = 4'h0;
    events  = 8'h00;
    for (int i = 0; i < `ZQC_NUM_BLOCKS; i++) begin
      busyVec[i]    = uo[i].busy;
      events[i]     = uo[i].doneEv;
      events[i + 4] = uo[i].errEv;
    end
  end

  always_comb begin
    hit    = 1'b1;
    rdData = 32'h0000_0000;
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr[7:4] == `ZQC_CR1_RGN) begin
      rdData = {15'h0, uo[idx].periodicEn, 8'h00,
                uo[idx].pad.divRatio}; // RULE2
    end else if (paddr[7:4] == `ZQC_SR0_RGN) begin
      // Word fields: ODT up 27:21, ODT down 20:14, drv up 13:7, drv down 6:0
      rdData = {uo[idx].done, uo[idx].err, 2'h0,
                uo[idx].pad.word}; // RULE2 RULE11
    end else if (paddr == `ZQC_CALCTL_ADDR) begin
      rdData = {12'h000, busyVec, 12'h000, st.calEn};
    end else if (paddr == `ZQC_IRQSTAT_ADDR) begin
      rdData = {24'h00_0000, st.irqStatus};
    end else if (paddr == `ZQC_IRQCLR_ADDR) begin
      rdData = 32'h0000_0000;
    end else if (paddr == `ZQC_IRQEN_ADDR) begin
      rdData = {24'h00_0000, st.irqEnable};
    end else if (paddr[7:4] == `ZQC_TGT_RGN) begin
      rdData = {16'h0000, odtOhms(uo[idx].pad.divRatio[7:4]),
                drvOhms(uo[idx].pad.divRatio[3:0])};
    end else begin
      hit = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // APB handshake
  // --------------------------------------------------------------------
  // One registered wait-free access: ready rises in the access phase
  assign accSetup = psel & ~penable;
  assign accWrite = psel & penable & st.pready & pwrite & hit;

  always_comb begin
    unitWr = 4'h0;
    if (accWrite && paddr[7:4] == `ZQC_CR1_RGN) begin
      unitWr[idx] = 1'b1; // RULE1
    end
  end

  always_comb begin
    next_st         = st;
    next_st.pready  = accSetup;
    next_st.pslverr = 1'b0;
    next_st.prdata  = 32'h0000_0000;
    next_st.trig    = 1'b0;
    if (accSetup) begin
      next_st.pslverr = ~hit;
      next_st.prdata  = pwrite ? 32'h0000_0000 : rdData;
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    if (accWrite && paddr == `ZQC_CALCTL_ADDR) begin
      next_st.calEn = pwdata[3:0];
      next_st.trig  = pwdata[`ZQC_TRIG_BIT]; // RULE12
    end
    if (accWrite && paddr == `ZQC_IRQEN_ADDR) begin
      next_st.irqEnable = pwdata[7:0];
    end
    if (accWrite && paddr == `ZQC_IRQCLR_ADDR) begin
      next_st.irqStatus = st.irqStatus & ~pwdata[7:0];
    end

    // New events win over a clear in the same cycle
    next_st.irqStatus = next_st.irqStatus | events;
    next_st.irq       = |(next_st.irqStatus & next_st.irqEnable);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st       <= '0;
      st.calEn <= `ZQC_CALEN_RST;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign irq     = st.irq;

  always_comb begin
    for (int i = 0; i < `ZQC_NUM_BLOCKS; i++) begin
      calStart[i]  = uo[i].calStart;
      updateReq[i] = uo[i].updateReq; // RULE3
      padCtrl[i]   = uo[i].pad; // RULE11
    end
  end

endmodule // zqc_regs

// file: verif/zqc_checker.sv
// Port assertions for the impedance register bank
`timescale 1ns/100ps
module zqc_checker (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       dfiUpdateReq,
  input wire zqc_pkg::zqc_result_t [3:0] calResult,
  input wire logic [3:0]                 calStart,
  input wire logic [3:0]                 updateReq,
  input wire zqc_pkg::zqc_pad_t [3:0]    padCtrl,
  input wire logic                       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_idle_quiet: assert property (!psel |-> !pready && prdata == 32'h0)
    else $error("bus output while idle");
  a_bad_addr_err: assert property (psel && penable && paddr[1:0] != 2'h0
    |-> pslverr) else $error("unaligned address not refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access phase");
  a_ctrl_resv_zero: assert property (
    pready && !pwrite && paddr[7:4] == 4'h0 |->
    prdata[31:17] == 15'h0 && prdata[15:8] == 8'h0)
    else $error("reserved control bits set");
  a_stat_resv_zero: assert property (
    pready && !pwrite && paddr[7:4] == 4'h1 |-> prdata[29:28] == 2'h0)
    else $error("reserved status bits set");
  a_word_by_result: assert property (
    $changed(padCtrl[0].word) && $past(resetn) |->
    $past(calResult[0].valid)) else $error("word moved without result");
  a_start_pulse: assert property (|calStart |=> calStart == 4'h0)
    else $error("start longer than one cycle");
  a_update_spacing: assert property (
    updateReq[0] |=> !updateReq[0] [*8])
    else $error("update requests too close");
endmodule // zqc_checker

// file: verif/zqc_pad_model.sv
// Behavioural pad calibration engine answering each start
`timescale 1ns/100ps
module zqc_pad_model (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [3:0]           calStart,
  input  wire logic [3:0][27:0]     wordIn,
  input  wire logic [3:0]           errIn,
  input  wire logic [7:0]           lat,
  output zqc_pkg::zqc_result_t [3:0] calResult
);
  int cnt [4];
  // Word toggles between results so a stale value is never reused
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!resetn) begin
        cnt[i] <= 0;
        calResult[i] <= '0;
      end else begin
        calResult[i].valid <= 1'b0;
        calResult[i].word <= ~calResult[i].word;
        if (calStart[i]) begin
          cnt[i] <= lat + 3 * i;
        end else if (cnt[i] == 1) begin
          calResult[i] <= {1'b1, errIn[i], wordIn[i]};
          cnt[i] <= 0;
        end else if (cnt[i] > 1) begin
          cnt[i] <= cnt[i] - 1;
        end
      end
    end
  end
endmodule // zqc_pad_model

// file: verif/zqc_regs_tb.sv
// Self-checking bench for the impedance register bank
`timescale 1ns/100ps
module zqc_regs_tb;
  logic                      clk, resetn, psel, penable, pwrite, pslverr;
  logic                      pready, irq, dfiUpdateReq, er;
  logic [7:0]                paddr, lat;
  logic [31:0]               pwdata, prdata, rd, xs, v, irqm;
  logic [3:0]                calStart, updateReq, errIn, en;
  logic [3:0][27:0]          wordIn;
  logic [31:0]               cr1m [4], srm [4];
  zqc_pkg::zqc_result_t [3:0] calResult;
  zqc_pkg::zqc_pad_t [3:0]    padCtrl;
  int num_errors, num_checks, startCnt [4], updCnt [4], expStart [4], b [4];
  int tu [3] = '{2, 5, 8};
  int ou [3] = '{120, 60, 40};
  int tl [2] = '{11, 13};
  int ol [2] = '{40, 34};

  zqc_regs u_dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dfiUpdateReq(dfiUpdateReq), .calResult(calResult),
    .calStart(calStart), .updateReq(updateReq), .padCtrl(padCtrl),
    .irq(irq));
  zqc_pad_model u_pad (.clk(clk), .resetn(resetn), .calStart(calStart),
    .wordIn(wordIn), .errIn(errIn), .lat(lat), .calResult(calResult));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      startCnt[i] += calStart[i];
      updCnt[i] += updateReq[i];
    end
  end

  // --------
  // Tasks
  // --------
  function automatic logic [31:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    // Taken at the edge that sees pready, before the slave moves on
    rd = prdata;
    er = pslverr;
    if (n == 16) begin
      num_errors++;
      stop_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task chk_irq(input logic e);
    @(negedge clk);
    chk("irq", 32'(e), 32'(irq));
    @(posedge clk);
  endtask

  // --------
  // Sequence
  // --------
  initial begin
    {clk, resetn, psel, penable, pwrite, dfiUpdateReq} = '0;
    {paddr, pwdata, errIn, wordIn, irqm} = '0;
    lat = 8'h01;
    xs = 32'h16;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      cr1m[i] = 32'h7B;
      srm[i] = 32'h14A;
      apb(0, 8'(4 * i), 0);
      chk("cr1 reset", cr1m[i], rd);
      apb(0, 8'h10 + 8'(4 * i), 0);
      chk("sr0 reset", srm[i], rd);
    end
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      apb(1, 8'(4 * i), v);
      cr1m[i] = v & 32'h0001_00FF;
    end
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(4 * i), 0);
      chk("cr1", cr1m[i], rd);
      chk("div", cr1m[i] & 32'hFF, 32'(padCtrl[i].divRatio));
    end
    apb(1, 8'h10, 32'hFFFF_FFFF);
    apb(0, 8'h10, 0);
    chk("sr0 ro", srm[0], rd);
    apb(0, 8'h41, 0);
    chk("slverr", 32'h1, 32'(er));
    $display("test regs done");
    for (int j = 0; j < 6; j++) begin
      v = {24'h0, 4'(tu[j / 2]), 4'(tl[j % 2])};
      apb(1, 8'(4 * (j % 4)), v);
      apb(0, 8'h30 + 8'(4 * (j % 4)), 0);
      chk("ohms", 32'(ou[j / 2] * 256 + ol[j % 2]), rd);
    end
    apb(1, 8'h00, 32'h0001_007B);
    @(negedge clk);
    for (int i = 0; i < 4; i++) b[i] = updCnt[i];
    repeat (800) @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < 4; i++)
      chk("updates", i == 0 ? 2 : 0, 32'(updCnt[i] - b[i]));
    @(posedge clk);
    $display("test periodic done");
    for (int r = 0; r < 2; r++) begin
      en = r ? 4'hD : 4'hF;
      lat <= 8'(1 + 6 * r);
      for (int i = 0; i < 4; i++) begin
        wordIn[i] <= 28'(rnd());
        errIn[i] <= xs[9];
      end
      if (r == 0) apb(1, 8'h20, {23'h0, 1'b1, 4'h0, en});
      else begin
        apb(1, 8'h20, {28'h0, en});
        dfiUpdateReq <= 1'b1;
        @(posedge clk);
        dfiUpdateReq <= 1'b0;
        apb(0, 8'h1C, 0);
        chk("sr0 start", srm[3] & 32'h0FFF_FFFF, rd);
      end
      repeat (30) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
        if (en[i]) begin
          expStart[i]++;
          srm[i] = {1'b1, errIn[i], 2'b0, wordIn[i]};
          irqm[i] = 1'b1;
          irqm[4 + i] = irqm[4 + i] | errIn[i];
        end
        chk("starts", 32'(expStart[i]), 32'(startCnt[i]));
        apb(0, 8'h10 + 8'(4 * i), 0);
        chk("sr0", srm[i], rd);
        chk("pad word", srm[i] & 32'hFFF_FFFF, 32'(padCtrl[i].word));
      end
    end
    $display("test calibration done");
    apb(0, 8'h24, 0);
    chk("irq status", irqm, rd);
    chk_irq(1'b0);
    apb(1, 8'h2C, 32'h2);
    chk_irq(1'b1);
    apb(1, 8'h28, 32'h2);
    chk_irq(1'b0);
    apb(0, 8'h24, 0);
    chk("irq cleared", irqm & ~32'h2, rd);
    $display("test irq done");
    stop_test;
  end
endmodule // zqc_regs_tb

bind zqc_regs zqc_checker u_chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dfiUpdateReq(dfiUpdateReq), .calResult(calResult), .calStart(calStart),
  .updateReq(updateReq), .padCtrl(padCtrl), .irq(irq));
